/* rtl/arb_pkg.sv */
// arb_pkg: register map, field layout and bus encodings of the per-slave arbiter
// assumes an AXI4-Lite register port and AHB-style master request signals
package arb_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          BEAT_W        = 11;
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_MCFG      = 12'h000;
  localparam logic [11:0] OFS_SCFG      = 12'h040;
  localparam logic [11:0] OFS_PRAS      = 12'h080;
  localparam logic [11:0] OFS_SYSIO     = 12'h114;
  localparam logic [11:0] OFS_WPMR      = 12'h1E4;
  localparam logic [11:0] OFS_WPSR      = 12'h1E8;
  // fields
  localparam int          SPLT_W        = 3;
  localparam logic [2:0]  SPLT_RST      = 3'h4;
  localparam logic [2:0]  SPLT_UNLIM    = 3'h0;
  localparam logic [2:0]  SPLT_SINGLE   = 3'h1;
  localparam int          SLOT_W        = 9;
  localparam logic [8:0]  SLOT_RST      = 9'h1FF;
  localparam int          POOL_W        = 2;
  localparam int          POOL_STRIDE   = 4;
  localparam logic [1:0]  POOL_BG       = 2'h0;
  localparam logic [1:0]  POOL_CRIT     = 2'h3;
  localparam int          PROT_EN_BIT   = 0;
  localparam int          KEY_LSB       = 8;
  localparam int          KEY_W         = 24;
  localparam int          VSRC_LSB      = 8;
  localparam int          VSRC_W        = 16;
  // ahb encodings
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HBURST_SINGLE = 3'h0;
  localparam logic [2:0]  HBURST_INCR   = 3'h1;
  localparam logic [2:0]  HBURST_X4A    = 3'h2;
  localparam logic [2:0]  HBURST_X4B    = 3'h3;
  localparam logic [2:0]  HBURST_X8A    = 3'h4;
  localparam logic [2:0]  HBURST_X8B    = 3'h5;
  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [0:0] {
    ST_FREE  = 1'b0,
    ST_OWNED = 1'b1
  } arb_state_e;
endpackage

/* rtl/pool_picker.sv */
// pool_picker: combinational winner selection among requesting masters
// assumes level vector packed POOL_W bits per master, rr pointers from the caller
`timescale 1ns/1ps
`default_nettype none
module pool_picker #(
  parameter int NM = 6,
  parameter int IW = 3
) (
  // requests and levels
  input  wire logic [NM-1:0]                 req,
  input  wire logic [NM*arb_pkg::POOL_W-1:0] levels,
  input  wire logic [IW-1:0]                 rr_hi,
  input  wire logic [IW-1:0]                 rr_lo,
  // result
  output logic                               win_valid,
  output logic [IW-1:0]                      win_idx
);
  import arb_pkg::*;
  logic [POOL_W-1:0] top;
  logic [IW-1:0]     ptr;
  int                k;
  always_comb begin
    top       = POOL_BG;
    win_valid = |req;
    win_idx   = '0;
    ptr       = '0;
    k         = 0;
    // the pool level always decides first
    for (int i = 0; i < NM; i++) begin
      if (req[i] && levels[i*POOL_W +: POOL_W] > top) begin
        top = levels[i*POOL_W +: POOL_W];
      end
    end
    if (top == POOL_CRIT || top == POOL_BG) begin
      ptr = (top == POOL_CRIT) ? rr_hi : rr_lo;
      // walk downward so the nearest index above the pointer wins last
      for (int i = NM; i >= 1; i--) begin
        k = (int'(ptr) + i) % NM;
        if (req[k] && levels[k*POOL_W +: POOL_W] == top) begin
          win_idx = IW'(k);
        end
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (req[i] && levels[i*POOL_W +: POOL_W] == top) begin
          win_idx = IW'(i);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/slave_arbiter.sv */
// slave_arbiter: arbiter for one slave port of a multi-master bus matrix
// assumes master request signals come from logic on aclk; registers over AXI4-Lite
//
// Summary of operation
// R01 - re-arbitrate only on idle, single access, burst end or slot expiry
// R02 - defined-length bursts end exactly at their last implied beat
// R03 - unlimited split setting makes no artificial burst end
// R04 - single split setting ends the burst at every INCR beat
// R05 - split settings 4..128 end the burst at each such beat boundary
// R06 - software should avoid splits of 8 beats or fewer
// R07 - slot counter loads the slot limit at each arbitration, then counts down
// R08 - expired slot counter allows re-arbitration at end of current access
// R09 - slot limit zero disables slot breaking
// R10 - four priority pools, 3 critical down to 0 background
// R11 - round-robin inside pools 3 and 0, fixed priority elsewhere
// R12 - pool level set per master by register, always evaluated first
// R13 - after reset masters sit in pool 0
// R14 - highest-pool requester in pool 3 or 0 waits at most one round of its pool
// R15 - larger pool level wins between pools
// R16 - within intermediate pools the highest master index wins
// R17 - pools 3 and 0 rotate through increasing master index
// R18 - software should keep processor masters at pool 2
// R19 - protect enable bit write-protects the configuration registers
// R20 - protected write sets violation flag and records the target offset
// R21 - writing the mode register with the right key clears the flag
// R22 - protection covers master, slave, priority and system registers
// R23 - split field 0 unlimited, 1 single, 2..7 four to 128 beats
// R24 - a blocked write leaves the register unchanged
// R25 - at most one grant per arbitration point, none without a request, held until the next
`timescale 1ns/1ps
`default_nettype none
module slave_arbiter #(
  parameter int                NM        = 6,
  parameter logic [23:0]       KEY       = 24'h5A3C71  // arbitrary value
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write
  input  wire logic [arb_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // axi4-lite read
  input  wire logic [arb_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // masters
  input  wire logic [NM*2-1:0]             m_htrans,
  input  wire logic [NM*3-1:0]             m_hburst,
  input  wire logic                        hready,
  // grant
  output logic [NM-1:0]                    grant,
  output logic [$clog2(NM)-1:0]            grant_idx,
  output logic                             arb_point
);
  import arb_pkg::*;
  localparam int IW = $clog2(NM);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit_mcfg(input logic [ADDR_W-1:0] a);
    return a >= OFS_MCFG && a < OFS_MCFG + ADDR_W'(NM * 4) && a[1:0] == 2'h0;
  endfunction

  function automatic logic [IW-1:0] mcfg_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_MCFG;
    return IW'(d[ADDR_W-1:2]);
  endfunction

  // protectable set: master, slave, priority and system registers
  function automatic logic hit_prot(input logic [ADDR_W-1:0] a);
    return hit_mcfg(a) || a == OFS_SCFG || a == OFS_PRAS || a == OFS_SYSIO; // R22
  endfunction

  // beats per arbitration segment, zero means no predicted end
  function automatic logic [BEAT_W-1:0] seg_len(input logic [2:0] hb, input logic [2:0] ul);
    logic [BEAT_W-1:0] n;
    case (hb)
      HBURST_SINGLE: n = BEAT_W'(1);
      HBURST_INCR: begin
        if (ul == SPLT_UNLIM) begin
          n = '0;                                          // R03
        end else if (ul == SPLT_SINGLE) begin
          n = BEAT_W'(1);                                  // R04
        end else begin
          n = BEAT_W'(1) << ul;                            // R05 R23
        end
      end
      HBURST_X4A, HBURST_X4B: n = BEAT_W'(4);              // R02
      HBURST_X8A, HBURST_X8B: n = BEAT_W'(8);
      default: n = BEAT_W'(16);
    endcase
    return n;
  endfunction

  // configuration state
  logic [SPLT_W-1:0] splt_ff [NM];
  logic [SLOT_W-1:0] slot_cfg_ff;
  logic [31:0]       prio_ff;
  logic [31:0]       sysio_ff;
  logic              protect_on_ff;
  logic              violation_flag_ff;
  logic [VSRC_W-1:0] violation_source_ff;

  // write channel state
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              do_write;
  logic              wr_blocked;
  logic              wr_mapped;

  assign awready    = !aw_held_ff && !bvalid;
  assign wready     = !w_held_ff && !bvalid;
  assign do_write   = aw_held_ff && w_held_ff && !bvalid;
  assign wr_blocked = protect_on_ff && hit_prot(waddr_ff);  // R19
  assign wr_mapped  = hit_prot(waddr_ff) || waddr_ff == OFS_WPMR || waddr_ff == OFS_WPSR;

  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        waddr_ff   <= awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NM; i++) begin
        splt_ff[i] <= SPLT_RST;
      end
    end else if (do_write && !wr_blocked && hit_mcfg(waddr_ff)) begin   // R24
      splt_ff[mcfg_idx(waddr_ff)] <= wstrb_ff[0] ? wdata_ff[SPLT_W-1:0]
                                                 : splt_ff[mcfg_idx(waddr_ff)];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_cfg_ff <= SLOT_RST;
      prio_ff     <= '0;                                   // R13
      sysio_ff    <= '0;
    end else if (do_write && !wr_blocked) begin            // R24
      if (waddr_ff == OFS_SCFG) begin
        slot_cfg_ff <= SLOT_W'(merge(32'(slot_cfg_ff), wdata_ff, wstrb_ff));
      end
      if (waddr_ff == OFS_PRAS) begin
        prio_ff <= merge(prio_ff, wdata_ff, wstrb_ff);
      end
      if (waddr_ff == OFS_SYSIO) begin
        sysio_ff <= merge(sysio_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  // a keyed mode write and a violation never meet in one cycle: one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protect_on_ff       <= 1'b0;
      violation_flag_ff   <= 1'b0;
      violation_source_ff <= '0;
    end else if (do_write) begin
      if (waddr_ff == OFS_WPMR && wdata_ff[KEY_LSB +: KEY_W] == KEY) begin
        protect_on_ff     <= wdata_ff[PROT_EN_BIT];        // R19
        violation_flag_ff <= 1'b0;                         // R21
      end
      if (wr_blocked) begin
        violation_flag_ff   <= 1'b1;                       // R20
        violation_source_ff <= VSRC_W'(waddr_ff);
      end
    end
  end

  // read channel
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    if (hit_mcfg(araddr)) begin
      rd_mux[SPLT_W-1:0] = splt_ff[mcfg_idx(araddr)];
    end else if (araddr == OFS_SCFG) begin
      rd_mux[SLOT_W-1:0] = slot_cfg_ff;
    end else if (araddr == OFS_PRAS) begin
      for (int i = 0; i < NM; i++) begin
        rd_mux[i*POOL_STRIDE +: POOL_W] = prio_ff[i*POOL_STRIDE +: POOL_W];
      end
    end else if (araddr == OFS_SYSIO) begin
      rd_mux = sysio_ff;
    end else if (araddr == OFS_WPMR) begin
      rd_mux[PROT_EN_BIT] = protect_on_ff;
    end else if (araddr == OFS_WPSR) begin
      rd_mux[0]                   = violation_flag_ff;
      rd_mux[VSRC_LSB +: VSRC_W]  = violation_source_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // arbitration
  arb_state_e        state_ff;
  logic [IW-1:0]     owner_ff;
  logic [IW-1:0]     rr_hi_ff;
  logic [IW-1:0]     rr_lo_ff;
  logic [BEAT_W-1:0] beat_ff;
  logic [SLOT_W-1:0] slot_cnt_ff;
  logic [1:0]        cur_trans;
  logic [2:0]        cur_burst;
  logic [BEAT_W-1:0] cur_beats;
  logic [BEAT_W-1:0] len;
  logic              idle_cyc;
  logic              last_beat;
  logic              slot_break;
  logic [NM-1:0]     req;
  logic [NM*POOL_W-1:0] levels;
  logic              win_valid;
  logic [IW-1:0]     win_idx;

  always_comb begin
    for (int i = 0; i < NM; i++) begin
      req[i]                      = m_htrans[i*2 +: 2] != HTRANS_IDLE;
      levels[i*POOL_W +: POOL_W]  = prio_ff[i*POOL_STRIDE +: POOL_W];   // R12
    end
  end

  assign cur_trans  = m_htrans[owner_ff*2 +: 2];
  assign cur_burst  = m_hburst[owner_ff*3 +: 3];
  assign cur_beats  = (cur_trans == HTRANS_NONSEQ) ? BEAT_W'(1) : beat_ff + BEAT_W'(1);
  assign len        = seg_len(cur_burst, splt_ff[owner_ff]);
  assign idle_cyc   = state_ff == ST_FREE || cur_trans == HTRANS_IDLE;
  // single access and burst end both land here; a zero length never matches
  assign last_beat  = hready && cur_trans[1] && len != '0
                      && (cur_beats & (len - BEAT_W'(1))) == '0;              // R02
  assign slot_break = slot_cfg_ff != '0 && slot_cnt_ff == '0
                      && hready && cur_trans[1];                              // R08 R09
  assign arb_point  = idle_cyc || last_beat || slot_break;                    // R01

  pool_picker #(
    .NM (NM),
    .IW (IW)
  ) u_pick (
    .req       (req),
    .levels    (levels),
    .rr_hi     (rr_hi_ff),
    .rr_lo     (rr_lo_ff),
    .win_valid (win_valid),
    .win_idx   (win_idx)    // R10 R11 R14 R15 R16 R17
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_FREE;
      owner_ff <= '0;
      rr_hi_ff <= IW'(NM - 1);
      rr_lo_ff <= IW'(NM - 1);
    end else if (arb_point) begin
      state_ff <= win_valid ? ST_OWNED : ST_FREE;          // R25
      owner_ff <= win_valid ? win_idx : owner_ff;
      if (win_valid && levels[win_idx*POOL_W +: POOL_W] == POOL_CRIT) begin
        rr_hi_ff <= win_idx;                               // R17
      end
      if (win_valid && levels[win_idx*POOL_W +: POOL_W] == POOL_BG) begin
        rr_lo_ff <= win_idx;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beat_ff <= '0;
    end else if (arb_point) begin
      beat_ff <= '0;
    end else if (hready && cur_trans[1]) begin
      beat_ff <= cur_beats;
    end
  end

  // counting stops at zero so an unbroken access stays breakable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_cnt_ff <= SLOT_RST;
    end else if (arb_point) begin
      slot_cnt_ff <= slot_cfg_ff;                          // R07
    end else if (slot_cnt_ff != '0) begin
      slot_cnt_ff <= slot_cnt_ff - SLOT_W'(1);
    end
  end

  always_comb begin
    grant = '0;
    if (state_ff == ST_OWNED) begin
      grant[owner_ff] = 1'b1;
    end
  end
  assign grant_idx = owner_ff;
endmodule
`default_nettype wire

/* bench/arb_monitor.sv */
// arb_monitor: port-level assertions on slave_arbiter
// assumes it is bound onto slave_arbiter and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module arb_monitor #(
  parameter int NM = 6
) (
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // register bus handshakes
  input wire logic                  awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic                  arvalid, arready, rvalid, rready,
  // masters and grant
  input wire logic [NM*2-1:0]       m_htrans,
  input wire logic [NM*3-1:0]       m_hburst,
  input wire logic                  hready,
  input wire logic [NM-1:0]         grant,
  input wire logic [$clog2(NM)-1:0] grant_idx,
  input wire logic                  arb_point
);
  import arb_pkg::*;
  logic [1:0]    own_tr;
  logic [2:0]    own_hb;
  logic [NM-1:0] reqv;
  always_comb begin
    own_tr = 2'h0;
    own_hb = 3'h0;
    for (int i = 0; i < NM; i++) begin
      reqv[i] = m_htrans[2*i +: 2] != HTRANS_IDLE;
      if (grant[i]) begin
        own_tr = m_htrans[2*i +: 2];
        own_hb = m_hburst[3*i +: 3];
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  a_grant_onehot: assert property ($onehot0(grant))
    else $error("more than one grant");
  a_idx_match: assert property (grant != '0 |-> grant[grant_idx])
    else $error("grant index disagrees with grant");
  a_grant_hold: assert property (!arb_point |=> $stable(grant))
    else $error("grant moved outside an arbitration cycle");
  a_free_arb: assert property (grant == '0 |-> arb_point)
    else $error("unowned slave not arbitrating");
  a_owner_idle: assert property (grant != '0 && own_tr == HTRANS_IDLE |-> arb_point)
    else $error("idle owner not arbitrating");
  a_single_end: assert property (own_tr[1] && own_hb == HBURST_SINGLE && hready |-> arb_point)
    else $error("single access did not end the tenure");
  a_grant_req: assert property (arb_point |=> grant == '0 || (grant & $past(reqv)) != '0)
    else $error("grant went to a master without a request");
  a_none_free: assert property (arb_point && reqv == '0 |=> grant == '0)
    else $error("grant without any request");
  a_wr_answer: assert property (s_wr_taken |-> ##[1:3] bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read data late");
endmodule
bind slave_arbiter arb_monitor #(.NM(NM)) arb_monitor_i (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .m_htrans(m_htrans), .m_hburst(m_hburst), .hready(hready), .grant(grant),
  .grant_idx(grant_idx), .arb_point(arb_point));
`default_nettype wire

/* bench/ahb_master_model.sv */
// ahb_master_model: NM behavioural bus masters plus the slave's ready
// assumes grant is registered on aclk; commands come from the bench
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model #(
  parameter int NM = 6
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // commands
  input  wire logic [NM-1:0] go_mask,
  input  wire logic [2:0]    go_burst,
  input  wire logic [7:0]    go_len,
  input  wire logic          slow,
  // bus side
  input  wire logic [NM-1:0] grant,
  output logic [NM*2-1:0]    m_htrans,
  output logic [NM*3-1:0]    m_hburst,
  output logic               hready,
  output logic               busy
);
  import arb_pkg::*;
  logic [7:0]    rem_ff [NM];
  logic [2:0]    kind_ff [NM];
  logic [NM-1:0] cont_ff;
  logic [4:0]    lfsr_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_ff <= 5'h01;
      cont_ff <= '0;
      for (int i = 0; i < NM; i++) begin
        rem_ff[i]  <= 8'h00;
        kind_ff[i] <= 3'h0;
      end
    end else begin
      lfsr_ff <= {lfsr_ff[3:0], lfsr_ff[4] ^ lfsr_ff[2]};
      for (int i = 0; i < NM; i++) begin
        if (grant[i] && hready && rem_ff[i] != 8'h00) begin
          rem_ff[i]  <= rem_ff[i] - 8'h01;
          cont_ff[i] <= rem_ff[i] != 8'h01;
        end else if (!grant[i]) begin
          cont_ff[i] <= 1'b0;
        end
        if (go_mask[i]) begin
          rem_ff[i]  <= go_len;
          kind_ff[i] <= go_burst;
        end
      end
    end
  end
  // a master that lost the bus restarts with a fresh nonseq beat
  always_comb begin
    busy = 1'b0;
    for (int i = 0; i < NM; i++) begin
      busy = busy | (rem_ff[i] != 8'h00);
      m_htrans[2*i +: 2] = rem_ff[i] == 8'h00 ? HTRANS_IDLE :
                           (grant[i] && cont_ff[i]) ? 2'h3 : HTRANS_NONSEQ;
      m_hburst[3*i +: 3] = rem_ff[i] == 8'h00 ? ~kind_ff[i] : kind_ff[i];
    end
  end
  assign hready = !slow || lfsr_ff[0];
endmodule
`default_nettype wire

/* bench/ahb_slave_arbiter_qos_test.sv */
// ahb_slave_arbiter_qos_test: self-checking bench for slave_arbiter
// assumes arb_pkg, the master model and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module ahb_slave_arbiter_qos_test;
  import arb_pkg::*;
  localparam int          NM   = 6;
  localparam logic [23:0] PKEY = 24'h5A3C71;  // arbitrary value
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, hready, arb_point, slow, busy;
  logic [11:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata, v;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [NM*2-1:0]   m_htrans;
  logic [NM*3-1:0]   m_hburst;
  logic [NM-1:0]     grant, prev_gnt, go_mask;
  logic [2:0]        grant_idx, go_burst;
  logic [7:0]        go_len, run;
  logic [65:0]       e;
  logic [65:0]       rdq[$];
  logic [1:0]        bq[$];
  logic [10:0]       gq[$];
  logic [11:0]       pofs[4];
  logic [31:0]       pold[4];
  int                error_cnt, num_checks, seed;
  slave_arbiter #(.NM(NM), .KEY(PKEY)) slave_arbiter_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .m_htrans(m_htrans), .m_hburst(m_hburst),
    .hready(hready), .grant(grant), .grant_idx(grant_idx), .arb_point(arb_point));
  ahb_master_model #(.NM(NM)) ahb_master_model_i (.aclk(aclk), .aresetn(aresetn),
    .go_mask(go_mask), .go_burst(go_burst), .go_len(go_len), .slow(slow), .grant(grant),
    .m_htrans(m_htrans), .m_hburst(m_hburst), .hready(hready), .busy(busy));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    // anything still expected was never seen
    if (rdq.size() + bq.size() + gq.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bad();
    error_cnt++;
    conclude();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (++n > 50) bad();
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    rdq.push_back({r, d, m});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (++n > 50) bad();
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic start(input logic [NM-1:0] m, input logic [2:0] b, input logic [7:0] l);
    @(posedge aclk);
    go_mask <= m;
    go_burst <= b;
    go_len <= l;
    @(posedge aclk);
    go_mask <= '0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      if (++n > 2000) bad();
    end while (busy || grant != '0);
  endtask
  // master 0 bursts ten beats, master 5 asks for one beat two cycles later
  task automatic pair(input int k);
    gq.push_back({3'd0, 8'd0});
    if (k == 0 || k >= 10) begin
      gq.push_back({3'd5, 8'd10});
    end else begin
      gq.push_back({3'd5, 8'(k)});
      gq.push_back({3'd0, 8'd1});
    end
    start(6'h01, HBURST_INCR, 8'd10);
    start(6'h20, HBURST_SINGLE, 8'd1);
    idle();
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = rdq.pop_front();
      check("rdata", {rresp, rdata & e[31:0]}, {e[65:64], e[63:32] & e[31:0]});
    end
    if (bvalid && bready) check("bresp", bresp, bq.pop_front());
  end
  // grant changes are paired with the beats done in the tenure that ended
  always @(negedge aclk) begin
    if (aresetn && grant !== prev_gnt) begin
      if (grant != '0) check("grant", {grant_idx, run}, gq.pop_front());
      run = 8'h00;
    end
    prev_gnt = grant;
    if (grant != '0 && hready && m_htrans[2*grant_idx +: 2] != HTRANS_IDLE) run++;
  end
  initial begin
    seed = 32'h86f7;
    run = 8'h00;
    prev_gnt = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, go_mask, go_burst, go_len} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NM; i++) rd(12'(4 * i), 32'h4);
    rd(OFS_SCFG, 32'h1FF);
    rd(OFS_PRAS, 32'h0);
    rd(OFS_SYSIO, 32'h0);
    rd(OFS_WPMR, 32'h0);
    rd(OFS_WPSR, 32'h0);
    rd(12'h200, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(12'h200, 32'h1, RESP_SLVERR);
    slow <= 1'b1;
    for (int i = 0; i < NM; i++) gq.push_back({3'(i), 8'(i != 0)});
    start(6'h3F, HBURST_SINGLE, 8'd1);
    idle();
    // masters 3 and 5 share pool 3 so its round-robin pointer moves too
    wr(OFS_PRAS, 32'h00313220);
    rd(OFS_PRAS, 32'h00313220);
    foreach (pold[i]) gq.push_back({3'(i == 0 ? 3 : i == 1 ? 5 : 4 - i), 8'(i != 0)});
    gq.push_back({3'd4, 8'd1});
    gq.push_back({3'd0, 8'd1});
    start(6'h3F, HBURST_SINGLE, 8'd1);
    idle();
    slow <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      wr(OFS_MCFG, s);
      rd(OFS_MCFG, s);
      pair(s == 0 ? 0 : s == 1 ? 2 : 1 << s);
    end
    wr(OFS_MCFG, 32'h0);
    wr(OFS_SCFG, 32'h3);
    pair(4);
    wr(OFS_SCFG, 32'h0);
    pair(0);
    v = $random(seed);
    wr(OFS_SYSIO, v);
    rd(OFS_SYSIO, v);
    pofs = '{12'h004, OFS_SCFG, OFS_PRAS, OFS_SYSIO};
    pold = '{32'h4, 32'h0, 32'h00313220, v};
    wr(OFS_WPMR, {PKEY, 8'h01});
    rd(OFS_WPMR, 32'h1);
    foreach (pofs[k]) begin
      wr(pofs[k], $random(seed));
      rd(pofs[k], pold[k]);
      rd(OFS_WPSR, {12'h0, pofs[k], 8'h01});
    end
    wr(OFS_WPMR, {~PKEY, 8'h00});
    rd(OFS_WPMR, 32'h1);
    wr(OFS_WPMR, {PKEY, 8'h00});
    rd(OFS_WPSR, 32'h0, 32'h1);
    wr(OFS_SYSIO, ~v);
    rd(OFS_SYSIO, ~v);
    repeat (4) @(posedge aclk);
    conclude();
  end
endmodule
`default_nettype wire
